// ===== rtl/fse_frame_stats.sv
`timescale 1ns/1ps
// ============================================================
// Frame statistics and exposure register block
module fse_frame_stats (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Pixel stream from the imager
  input  wire logic        pix_valid,
  input  wire logic        pix_first,
  input  wire logic        pix_last,
  input  wire logic [6:0]  pix_data,
  // Feature count from the tracker
  input  wire logic        feat_valid,
  input  wire logic [9:0]  feat_count,
  // Links to the rest of the unit
  input  wire logic        gain_loop_off,
  input  wire logic [15:0] expo_max_bound,
  // Register port behind the serial interface
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // Current exposure for the imager
  output logic [15:0]      expo_value
);

  logic [16:0] st_sum;                 // Frame sum
  logic [6:0]  st_max;                 // Frame brightest
  logic [6:0]  st_min;                 // Frame darkest
  logic        st_done;                // Frame complete
  logic [7:0]  qual_ff, nxt_qual;      // Surface quality
  logic [7:0]  sum_ff, nxt_sum;        // Intensity total
  logic [6:0]  max_ff, nxt_max;        // Brightest pixel
  logic [6:0]  min_ff, nxt_min;        // Darkest pixel
  logic [15:0] expo_ff, nxt_expo;      // Exposure count
  logic [7:0]  shadow_ff, nxt_shadow;  // Captured low byte
  logic [7:0]  rdata_ff, nxt_rdata;    // Read data
  logic        rvalid_ff, nxt_rvalid;  // Read answer pulse
  logic [7:0]  sum_byte;               // Truncated frame sum
  logic        unused_w;               // Write data not stored

  // Saturate an 8-bit value at a ceiling
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lim);
    clamp8 = (v > lim) ? lim : v;
  endfunction : clamp8

  // Saturate a 16-bit value at a ceiling
  function automatic logic [15:0] clamp16(input logic [16:0] v,
                                          input logic [15:0] lim);
    clamp16 = (v > {1'b0, lim}) ? lim : v[15:0];
  endfunction : clamp16

  // ==========================================================
  // Pixel statistics
  fse_pix_stats u_stats (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .pix_valid  (pix_valid),
    .pix_first  (pix_first),
    .pix_last   (pix_last),
    .pix_data   (pix_data),
    .frame_sum  (st_sum),
    .frame_max  (st_max),
    .frame_min  (st_min),
    .frame_done (st_done)
  );

  // Only the upper byte of the sum is kept
  assign sum_byte = st_sum[16:fse_pkg::SUM_LSB];
  // Writes are accepted and dropped
  assign unused_w = reg_wr & (|reg_wdata);

  // ==========================================================
  // Statistics and exposure next values
  always_comb begin
    nxt_qual = qual_ff;
    nxt_sum  = sum_ff;
    nxt_max  = max_ff;
    nxt_min  = min_ff;
    nxt_expo = expo_ff;
    // Quality is the count over four, capped
    if (feat_valid) begin
      nxt_qual = clamp8(feat_count[9:fse_pkg::FEAT_LSB],
                        fse_pkg::QUALITY_MAX);
    end
    if (st_done) begin
      nxt_sum = clamp8(sum_byte, fse_pkg::PIX_SUM_MAX);
      nxt_max = st_max;
      nxt_min = st_min;
      if (gain_loop_off) begin
        // Manual mode holds the bound exactly
        nxt_expo = expo_max_bound;
      end else if (sum_byte < fse_pkg::AGC_LOW) begin
        // Too dark: lengthen, never past the bound
        nxt_expo = clamp16({1'b0, expo_ff} + {1'b0, fse_pkg::AGC_STEP},
                           expo_max_bound);
      end else if (sum_byte > fse_pkg::AGC_HIGH) begin
        // Too bright: shorten, floor at one step
        // Subtract only while the result stays at or above one step
        nxt_expo = clamp16((expo_ff >= {fse_pkg::AGC_STEP[14:0], 1'b0}) ?
                           {1'b0, expo_ff - fse_pkg::AGC_STEP} :
                           {1'b0, fse_pkg::AGC_STEP},
                           expo_max_bound);
      end else begin
        // In range, but a lowered bound still applies
        nxt_expo = clamp16({1'b0, expo_ff}, expo_max_bound);
      end
    end
  end

  // ==========================================================
  // Read path next values
  always_comb begin
    nxt_shadow = shadow_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    if (reg_rd) begin
      nxt_rvalid = 1'b1;
      if (reg_addr == fse_pkg::ADDR_QUALITY) begin
        nxt_rdata = qual_ff;
      end else if (reg_addr == fse_pkg::ADDR_PIX_SUM) begin
        nxt_rdata = sum_ff;
      end else if (reg_addr == fse_pkg::ADDR_PIX_MAX) begin
        nxt_rdata = {1'b0, max_ff};
      end else if (reg_addr == fse_pkg::ADDR_PIX_MIN) begin
        nxt_rdata = {1'b0, min_ff};
      end else if (reg_addr == fse_pkg::ADDR_EXPO_HI) begin
        // Freeze the partner byte so the pair is coherent
        nxt_rdata  = expo_ff[15:8];
        nxt_shadow = expo_ff[7:0];
      end else if (reg_addr == fse_pkg::ADDR_EXPO_LO) begin
        nxt_rdata = shadow_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      qual_ff   <= fse_pkg::RST_STAT;
      sum_ff    <= fse_pkg::RST_STAT;
      max_ff    <= 7'h00;
      min_ff    <= 7'h00;
      expo_ff   <= fse_pkg::RST_EXPO;
      shadow_ff <= fse_pkg::RST_EXPO_LO;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      qual_ff   <= nxt_qual;
      sum_ff    <= nxt_sum;
      max_ff    <= nxt_max;
      min_ff    <= nxt_min;
      expo_ff   <= nxt_expo;
      shadow_ff <= nxt_shadow;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign expo_value = expo_ff;

  // ==========================================================
  // Assertions
  property p_qual_cap;
    @(posedge core_clk) disable iff (sys_rst) qual_ff <= 8'ha9;
  endproperty
  a_qual_cap: assert property (p_qual_cap)
    else $error("quality above cap");

  property p_qual_scale;
    @(posedge core_clk) disable iff (sys_rst)
      (feat_valid && feat_count < 10'h2a4) |=>
        qual_ff == $past(feat_count[9:2]);
  endproperty
  a_qual_scale: assert property (p_qual_scale)
    else $error("quality not count over four");

  property p_sum_cap;
    @(posedge core_clk) disable iff (sys_rst) sum_ff <= 8'hdf;
  endproperty
  a_sum_cap: assert property (p_sum_cap)
    else $error("pixel total above cap");

  property p_sum_upd;
    @(posedge core_clk) disable iff (sys_rst)
      (st_done && st_sum[16:9] <= 8'hdf) |=> sum_ff == $past(st_sum[16:9]);
  endproperty
  a_sum_upd: assert property (p_sum_upd)
    else $error("pixel total not sum over 512");

  property p_extremes;
    @(posedge core_clk) disable iff (sys_rst)
      st_done |=> (max_ff == $past(st_max)) && (min_ff == $past(st_min));
  endproperty
  a_extremes: assert property (p_extremes)
    else $error("extremes not updated");

  property p_bound;
    @(posedge core_clk) disable iff (sys_rst)
      st_done |=> expo_ff <= $past(expo_max_bound);
  endproperty
  a_bound: assert property (p_bound)
    else $error("exposure above bound");

  property p_manual;
    @(posedge core_clk) disable iff (sys_rst)
      (st_done && gain_loop_off) |=> expo_ff == $past(expo_max_bound);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual exposure not applied");

  property p_agc_up;
    @(posedge core_clk) disable iff (sys_rst)
      (st_done && !gain_loop_off && st_sum[16:9] < 8'h50 &&
       expo_ff < expo_max_bound) |=> expo_ff > $past(expo_ff);
  endproperty
  a_agc_up: assert property (p_agc_up)
    else $error("dark frame did not lengthen exposure");

  property p_coherent;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == 7'h0c) ##1 (reg_rd && reg_addr == 7'h0b)
        |=> reg_rdata == $past(expo_ff[7:0], 2);
  endproperty
  a_coherent: assert property (p_coherent)
    else $error("low byte not coherent with high");

  property p_ro;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && !st_done && !feat_valid) |=>
        $stable(expo_ff) && $stable(qual_ff) && $stable(sum_ff);
  endproperty
  a_ro: assert property (p_ro)
    else $error("write changed a register");

  property p_rd_answer;
    @(posedge core_clk) disable iff (sys_rst)
      reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");

  c_frame:  cover property (@(posedge core_clk) st_done);
  c_manual: cover property (@(posedge core_clk) st_done && gain_loop_off);
  c_pair:   cover property (@(posedge core_clk)
    (reg_rd && reg_addr == 7'h0c) ##1 (reg_rd && reg_addr == 7'h0b));

endmodule : fse_frame_stats

// ===== rtl/fse_pkg.sv
// Overview of operation
// - Quality reads top byte of feature count
// - Quality register never exceeds 169
// - Seventeen-bit pixel sum, upper byte reported
// - Pixel total 0..223, new each frame
// - Brightest pixel, seven bits, each frame
// - Darkest pixel, seven bits, each frame
// - Sixteen-bit exposure, low 0x0B, high 0x0C
// - Automatic loop adjusts exposure after frames with total outside 0x50..0x90
// - Manual exposure via loop off and bound
// - Exposure clamped to maximum bound at each frame end
// - Loop off sets exposure to bound at each frame end
package fse_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [6:0] ADDR_QUALITY  = 7'h07; // Surface quality
  localparam logic [6:0] ADDR_PIX_SUM  = 7'h08; // Intensity total
  localparam logic [6:0] ADDR_PIX_MAX  = 7'h09; // Brightest pixel
  localparam logic [6:0] ADDR_PIX_MIN  = 7'h0a; // Darkest pixel
  localparam logic [6:0] ADDR_EXPO_LO  = 7'h0b; // Exposure low byte
  localparam logic [6:0] ADDR_EXPO_HI  = 7'h0c; // Exposure high byte

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_EXPO_LO  = 8'h20;
  localparam logic [7:0]  RST_EXPO_HI  = 8'h4e;
  localparam logic [15:0] RST_EXPO     = {RST_EXPO_HI, RST_EXPO_LO};
  localparam logic [7:0]  RST_STAT     = 8'h00;

  // ==========================================================
  // Field limits and positions
  localparam logic [7:0]  QUALITY_MAX  = 8'ha9;  // 169
  localparam logic [7:0]  PIX_SUM_MAX  = 8'hdf;  // 223
  localparam int          SUM_LSB      = 9;      // Divide by 512
  localparam int          FEAT_LSB     = 2;      // Divide by 4

  // ==========================================================
  // Exposure loop tuning
  localparam logic [7:0]  AGC_LOW      = 8'h50;  // Too dark below
  localparam logic [7:0]  AGC_HIGH     = 8'h90;  // Too bright above
  localparam logic [15:0] AGC_STEP     = 16'h0100;

  // Statistics collector states, Gray along the path
  typedef enum logic [1:0] {
    FSE_IDLE = 2'b00,
    FSE_ACC  = 2'b01
  } fse_stat_e;

endpackage : fse_pkg

// ===== rtl/fse_pix_stats.sv
`timescale 1ns/1ps
// ============================================================
// Per-frame sum, brightest and darkest pixel collector
module fse_pix_stats (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Pixel stream
  input  wire logic        pix_valid,
  input  wire logic        pix_first,
  input  wire logic        pix_last,
  input  wire logic [6:0]  pix_data,
  // Frame results
  output logic [16:0]      frame_sum,
  output logic [6:0]       frame_max,
  output logic [6:0]       frame_min,
  output logic             frame_done
);

  fse_pkg::fse_stat_e state_ff, nxt_state;   // Collector state
  logic [16:0] acc_ff, nxt_acc;              // Running sum
  logic [6:0]  hi_ff, nxt_hi;                // Running max
  logic [6:0]  lo_ff, nxt_lo;                // Running min
  logic [16:0] sum_ff, nxt_sum;              // Held frame sum
  logic [6:0]  max_ff, nxt_max;              // Held frame max
  logic [6:0]  min_ff, nxt_min;              // Held frame min
  logic        done_ff, nxt_done;            // Frame end pulse
  logic [16:0] add_v;                        // Sum with this pixel
  logic [6:0]  hi_v;                         // Max with this pixel
  logic [6:0]  lo_v;                         // Min with this pixel

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_acc   = acc_ff;
    nxt_hi    = hi_ff;
    nxt_lo    = lo_ff;
    nxt_sum   = sum_ff;
    nxt_max   = max_ff;
    nxt_min   = min_ff;
    nxt_done  = 1'b0;
    // First pixel restarts, so a lost end never poisons a frame
    if (pix_first) begin
      add_v = {10'h000, pix_data};
      hi_v  = pix_data;
      lo_v  = pix_data;
    end else begin
      add_v = acc_ff + {10'h000, pix_data};
      hi_v  = (pix_data > hi_ff) ? pix_data : hi_ff;
      lo_v  = (pix_data < lo_ff) ? pix_data : lo_ff;
    end
    if (pix_valid && (pix_first || state_ff == fse_pkg::FSE_ACC)) begin
      nxt_acc = add_v;
      nxt_hi  = hi_v;
      nxt_lo  = lo_v;
      if (pix_last) begin
        // Publish the completed frame
        nxt_sum   = add_v;
        nxt_max   = hi_v;
        nxt_min   = lo_v;
        nxt_done  = 1'b1;
        nxt_state = fse_pkg::FSE_IDLE;
      end else begin
        nxt_state = fse_pkg::FSE_ACC;
      end
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= fse_pkg::FSE_IDLE;
      acc_ff   <= 17'h00000;
      hi_ff    <= 7'h00;
      lo_ff    <= 7'h00;
      sum_ff   <= 17'h00000;
      max_ff   <= 7'h00;
      min_ff   <= 7'h00;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      acc_ff   <= nxt_acc;
      hi_ff    <= nxt_hi;
      lo_ff    <= nxt_lo;
      sum_ff   <= nxt_sum;
      max_ff   <= nxt_max;
      min_ff   <= nxt_min;
      done_ff  <= nxt_done;
    end
  end

  assign frame_sum  = sum_ff;
  assign frame_max  = max_ff;
  assign frame_min  = min_ff;
  assign frame_done = done_ff;

endmodule : fse_pix_stats

// ===== bench/fse_mcu_model.sv
`timescale 1ns/1ps
// ============================================================
// Controller stand-in that reads the register port
module fse_mcu_model (
  // Clock
  input  wire logic       core_clk,
  // Requests towards the block
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [6:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  // Answers from the block
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Idle state at time zero
  initial begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  // Single read, answer sampled just after the taking edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d        = reg_rvalid ? reg_rdata : 8'hxx;
    reg_rd   = 1'b0;
    reg_addr = ~a; // Stale address scrambled so it is never relied on
  endtask : rd

  // Exposure pair: high then low, back to back, nothing between
  task automatic rd_expo(output logic [15:0] v);
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = fse_pkg::ADDR_EXPO_HI;
    @(posedge core_clk);
    #1;
    v[15:8]  = reg_rvalid ? reg_rdata : 8'hxx;
    reg_addr = fse_pkg::ADDR_EXPO_LO;
    @(posedge core_clk);
    #1;
    v[7:0]   = reg_rvalid ? reg_rdata : 8'hxx;
    reg_rd   = 1'b0;
    reg_addr = 7'h73;
  endtask : rd_expo

  // Write pulse; the block is expected to drop it
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr
endmodule : fse_mcu_model

// ===== bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
// ============================================================
// Self-checking bench for the statistics and exposure block
module tb;
  // One frame row: stimulus and settings beside the expected results
  typedef struct {
    int          n;
    logic [6:0]  mid, hi, lo;
    logic [9:0]  feat;
    logic        off;
    logic [15:0] bnd;
    logic [7:0]  q, s, mx, mn;  // Quality, total, brightest, darkest
    logic [15:0] ex;            // Exposure after the frame
  } fse_row_s;
  logic        core_clk, sys_rst, pix_valid, pix_first, pix_last;
  logic [6:0]  pix_data;
  logic        feat_valid, gain_loop_off, reg_rd, reg_wr, reg_rvalid;
  logic [9:0]  feat_count;
  logic [15:0] expo_max_bound, expo_value, v, e;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  int          errors, n_checks;
  fse_row_s    rows [5];

  // ==========================================================
  // Design and controller
  fse_frame_stats u_fse_frame_stats (.core_clk(core_clk), .sys_rst(sys_rst),
    .pix_valid(pix_valid), .pix_first(pix_first), .pix_last(pix_last),
    .pix_data(pix_data), .feat_valid(feat_valid), .feat_count(feat_count),
    .gain_loop_off(gain_loop_off), .expo_max_bound(expo_max_bound),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .expo_value(expo_value));
  fse_mcu_model u_fse_mcu_model (.core_clk(core_clk), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Imager stand-in: first pixel hi, second lo, rest mid
  task automatic frame(input int n, input logic [6:0] mid, hi, lo);
    logic [6:0] p;
    for (int i = 0; i < n; i++) begin
      p = (i == 0) ? hi : ((i == 1) ? lo : mid);
      @(posedge core_clk);
      #1;
      pix_valid = 1'b1;
      pix_first = (i == 0);
      pix_last  = (i == n - 1);
      pix_data  = p;
    end
    @(posedge core_clk);
    #1;
    pix_valid = 1'b0;
    pix_first = 1'b0;
    pix_last  = 1'b0;
    repeat (3) @(posedge core_clk); // Results land two edges after last
  endtask : frame

  // Watchdog, far beyond the few thousand cycles of the run
  initial begin
    repeat (50000) @(posedge core_clk);
    errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {pix_valid, pix_first, pix_last, feat_valid, gain_loop_off} = 5'h00;
    pix_data = 7'h00;
    feat_count = 10'h000;
    expo_max_bound = 16'hffff;
    errors = 0;
    n_checks = 0;
    e = 16'h4e20;
    // Bright full frame, capped quality: exposure shortens by a step
    rows[0] = '{900, 7'h7f, 7'h7f, 7'h7f, 10'h3ff, 1'b0, 16'hffff,
                8'ha9, 8'hdf, 8'h7f, 8'h7f, 16'h4d20};
    // Mid-range frame: exposure holds
    rows[1] = '{900, 7'h3c, 7'h64, 7'h03, 10'h2a4, 1'b0, 16'hffff,
                8'ha9, 8'h69, 8'h64, 8'h03, 16'h4d20};
    // Dark short frame: lengthening is stopped by the bound
    rows[2] = '{10,  7'h05, 7'h09, 7'h00, 10'h190, 1'b0, 16'h4e00,
                8'h64, 8'h00, 8'h09, 8'h00, 16'h4e00};
    // Manual row; a fixed frame rate is kept outside this block
    rows[3] = '{1,   7'h10, 7'h4d, 7'h10, 10'h003, 1'b1, 16'h1234,
                8'h00, 8'h00, 8'h4d, 8'h4d, 16'h1234};
    // Loop back on: bright frame shortens from the manual value
    rows[4] = '{900, 7'h7f, 7'h7f, 7'h7f, 10'h2bc, 1'b0, 16'hffff,
                8'ha9, 8'hdf, 8'h7f, 8'h7f, 16'h1134};
    sys_rst = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    // Reset contents and an unmapped offset
    `CHK("expo_value", 16'h4e20, expo_value)
    u_fse_mcu_model.rd_expo(v);
    `CHK("expo_pair", 16'h4e20, v)
    for (int a = 7; a < 11; a++) begin
      u_fse_mcu_model.rd(7'(a), d);
      `CHK("stat_reset", 8'h00, d)
    end
    u_fse_mcu_model.rd(7'h7f, d);
    `CHK("unmapped", 8'h00, d)
    // Writes must not land
    u_fse_mcu_model.wr(fse_pkg::ADDR_EXPO_HI, 8'hff);
    u_fse_mcu_model.wr(fse_pkg::ADDR_QUALITY, 8'h55);
    u_fse_mcu_model.rd_expo(v);
    `CHK("expo_after_wr", 16'h4e20, v)
    u_fse_mcu_model.rd(fse_pkg::ADDR_QUALITY, d);
    `CHK("qual_after_wr", 8'h00, d)
    // Row loop: feature pulse, one frame, then every register
    foreach (rows[r]) begin
      gain_loop_off  = rows[r].off;
      expo_max_bound = rows[r].bnd;
      @(posedge core_clk);
      #1;
      feat_valid = 1'b1;
      feat_count = rows[r].feat;
      @(posedge core_clk);
      #1;
      feat_valid = 1'b0;
      frame(rows[r].n, rows[r].mid, rows[r].hi, rows[r].lo);
      e = rows[r].ex;
      u_fse_mcu_model.rd(fse_pkg::ADDR_QUALITY, d);
      `CHK("quality", rows[r].q, d)
      u_fse_mcu_model.rd(fse_pkg::ADDR_PIX_SUM, d);
      `CHK("pix_sum", rows[r].s, d)
      u_fse_mcu_model.rd(fse_pkg::ADDR_PIX_MAX, d);
      `CHK("pix_max", rows[r].mx, d)
      u_fse_mcu_model.rd(fse_pkg::ADDR_PIX_MIN, d);
      `CHK("pix_min", rows[r].mn, d)
      `CHK("expo", e, expo_value)
      u_fse_mcu_model.rd_expo(v);
      `CHK("expo_pair", e, v)
    end
    // Stray pixel with no frame start is dropped
    @(posedge core_clk);
    #1;
    {pix_valid, pix_last, pix_data} = {2'b11, 7'h00};
    @(posedge core_clk);
    #1;
    {pix_valid, pix_last} = 2'b00;
    repeat (3) @(posedge core_clk);
    u_fse_mcu_model.rd(fse_pkg::ADDR_PIX_MIN, d);
    `CHK("stray_min", rows[4].mn, d)
    // Lone low read returns the byte captured by the last high read
    u_fse_mcu_model.rd(fse_pkg::ADDR_EXPO_LO, d);
    `CHK("lone_low", e[7:0], d)
    // Second reset in mid-run
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    `CHK("expo_rst2", 16'h4e20, expo_value)
    u_fse_mcu_model.rd(fse_pkg::ADDR_QUALITY, d);
    `CHK("qual_rst2", 8'h00, d)
    final_report();
  end
endmodule : tb
